// ### design/cscr_regs.sv
// core system control register bank with its AHB-Lite slave and core-side controls
// How it works
// - wake-on-pending lets disabled interrupts wake too
// - pending event wakes wait, else latched
// - send-event or external event also wakes
// - deep-sleep bit chooses sleep versus deep
// - sleep on handler-to-thread return when set
// - stacked bit 9 records and restores padding
// - alignment bit picks 4 or 8 byte frame
// - top handlers ignore bus faults, else lockup
// - divide-trap bit traps zero divisor divides
// - untrapped zero divide gives quotient zero
// - misalignment-trap bit faults unaligned half/word
// - unaligned multiple/doubleword accesses always fault
// - trigger bit gates unprivileged interrupt trigger writes
// - thread entry only at base unless enabled
// - byte-accessible priorities for configurable handlers
// - fields 4,5,6 / 11 / 14,15 per register
// - low four priority bits read zero
// - privileged access only; reserved bits written zero
// - preemption uses only group priority bits
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module cscr_regs (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // register bus
    input wire cscr_pkg::cscr_ahb_req_t ahb_in,
    output cscr_pkg::cscr_ahb_rsp_t ahb_out,
    // core side
    input wire cscr_pkg::cscr_core_in_t core_in,
    output cscr_pkg::cscr_core_out_t core_out
);
    import cscr_pkg::*;

    typedef struct packed {
        logic wake_any;
        logic deep_sel;
        logic after_handler;
        logic align8;
        logic bf_ignore;
        logic div_trap;
        logic misalign_trap;
        logic unpriv_trig;
        logic thread_any;
        logic [CSCR_PRI_COUNT-1:0][3:0] pri;
        logic ph_valid;
        logic ph_write;
        logic [7:0] ph_addr;
        logic [2:0] ph_size;
        logic [31:0] rdata;
        cscr_lp_state_t lp_state;
        logic event_latch;
        cscr_core_out_t o;
    } cscr_state_t;

    cscr_state_t st_reg;
    cscr_state_t st_next;

    // byte lanes touched by a transfer of the given size
    function automatic logic [31:0] lane_mask(input logic [2:0] size, input logic [1:0] addr);
        logic [31:0] m;
        m = 32'h0000_0000;
        unique case (size)
            3'h0: m = 32'h0000_00FF << {addr, 3'h0};
            3'h1: m = addr[1] ? 32'hFFFF_0000 : 32'h0000_FFFF;
            default: m = 32'hFFFF_FFFF;
        endcase
        return m;
    endfunction

    // read image of one register; reserved and unimplemented bits are zero
    function automatic logic [31:0] read_word(input cscr_state_t s, input logic [7:0] addr);
        logic [31:0] w;
        w = 32'h0000_0000;
        unique case (addr)
            CSCR_OFS_LOW_POWER: begin
                w[CSCR_LP_WAKE_ANY_BIT] = s.wake_any;
                w[CSCR_LP_DEEP_BIT] = s.deep_sel;
                w[CSCR_LP_AFTER_HANDLER_BIT] = s.after_handler;
            end
            CSCR_OFS_CORE_CFG: begin
                w[CSCR_CC_ALIGN8_BIT] = s.align8;
                w[CSCR_CC_BF_IGNORE_BIT] = s.bf_ignore;
                w[CSCR_CC_DIV_TRAP_BIT] = s.div_trap;
                w[CSCR_CC_MISALIGN_BIT] = s.misalign_trap;
                w[CSCR_CC_UNPRIV_TRIG_BIT] = s.unpriv_trig;
                w[CSCR_CC_THREAD_ANY_BIT] = s.thread_any;
            end
            CSCR_OFS_PRI1: w = {8'h00, s.pri[2], 4'h0, s.pri[1], 4'h0, s.pri[0], 4'h0};
            CSCR_OFS_PRI2: w = {s.pri[3], 4'h0, 24'h00_0000};
            CSCR_OFS_PRI3: w = {s.pri[5], 4'h0, s.pri[4], 4'h0, 16'h0000};
            default: w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    // keep only the group part of a priority for the current binary point
    function automatic logic [7:0] group_part(input logic [3:0] pri, input logic [2:0] grp);
        logic [7:0] m;
        m = 8'hF0;
        unique case (grp)
            3'h4: m = 8'hE0;
            3'h5: m = 8'hC0;
            3'h6: m = 8'h80;
            3'h7: m = 8'h00;
            default: m = 8'hF0;
        endcase
        return {pri, 4'h0} & m;
    endfunction

    logic [31:0] wmask;
    logic [31:0] wword;
    logic wake_src;
    logic addr_phase;
    logic [7:0] waddr;

    always_comb begin
        st_next = st_reg;
        // byte writes to an upper priority byte decode on the word, the lanes pick the byte
        waddr = {st_reg.ph_addr[7:2], 2'h0};
        wmask = lane_mask(st_reg.ph_size, st_reg.ph_addr[1:0]);
        wword = (read_word(st_reg, waddr) & ~wmask) | (ahb_in.hwdata & wmask);
        addr_phase = ahb_in.hsel && ahb_in.hready && ahb_in.htrans == CSCR_HTRANS_NONSEQ;

        // data phase of a write; reserved bits never reach storage
        if (st_reg.ph_valid && st_reg.ph_write) begin
            unique case (waddr)
                CSCR_OFS_LOW_POWER: begin
                    st_next.wake_any = wword[CSCR_LP_WAKE_ANY_BIT];
                    st_next.deep_sel = wword[CSCR_LP_DEEP_BIT];
                    st_next.after_handler = wword[CSCR_LP_AFTER_HANDLER_BIT];
                end
                CSCR_OFS_CORE_CFG: begin
                    st_next.align8 = wword[CSCR_CC_ALIGN8_BIT];
                    st_next.bf_ignore = wword[CSCR_CC_BF_IGNORE_BIT];
                    st_next.div_trap = wword[CSCR_CC_DIV_TRAP_BIT];
                    st_next.misalign_trap = wword[CSCR_CC_MISALIGN_BIT];
                    st_next.unpriv_trig = wword[CSCR_CC_UNPRIV_TRIG_BIT];
                    st_next.thread_any = wword[CSCR_CC_THREAD_ANY_BIT];
                end
                CSCR_OFS_PRI1: begin
                    st_next.pri[0] = wword[7:4];
                    st_next.pri[1] = wword[15:12];
                    st_next.pri[2] = wword[23:20];
                end
                CSCR_OFS_PRI2: st_next.pri[3] = wword[31:28];
                CSCR_OFS_PRI3: begin
                    st_next.pri[4] = wword[23:20];
                    st_next.pri[5] = wword[31:28];
                end
                default: st_next.pri = st_reg.pri;
            endcase
        end

        // unprivileged transfers are taken but neither store nor return data
        st_next.ph_valid = addr_phase && ahb_in.hprot[1];
        st_next.ph_write = ahb_in.hwrite;
        st_next.ph_addr = ahb_in.haddr[7:0];
        st_next.ph_size = ahb_in.hsize;
        // read taken from the updated copy so a write just before is seen
        st_next.rdata = (st_next.ph_valid && !ahb_in.hwrite) ?
            read_word(st_next, {ahb_in.haddr[7:2], 2'h0}) : 32'h0000_0000;

        // wake sources; disabled interrupts count only with wake-on-pending
        wake_src = core_in.send_event_instr || core_in.ext_event || core_in.enabled_event ||
            core_in.enabled_irq_pending || (st_reg.wake_any && core_in.disabled_irq_pending);
        st_next.o.wake = 1'b0;
        st_next.event_latch = st_reg.event_latch;
        unique case (st_reg.lp_state)
            CSCR_LP_RUN: begin
                if (core_in.wait_for_event_instr && (st_reg.event_latch || wake_src)) begin
                    st_next.event_latch = 1'b0;
                end else if (core_in.wait_for_event_instr) begin
                    st_next.lp_state = CSCR_LP_EVENT_WAIT;
                end else if (wake_src) begin
                    st_next.event_latch = 1'b1;
                end
                if (core_in.handler_exit && st_reg.after_handler && !core_in.wait_for_event_instr) begin
                    st_next.lp_state = CSCR_LP_SLEEP;
                end
            end
            CSCR_LP_EVENT_WAIT: begin
                if (wake_src) begin
                    st_next.lp_state = CSCR_LP_RUN;
                    st_next.o.wake = 1'b1;
                end
            end
            CSCR_LP_SLEEP: begin
                if (core_in.enabled_irq_pending ||
                    (st_reg.wake_any && core_in.disabled_irq_pending)) begin
                    st_next.lp_state = CSCR_LP_RUN;
                    st_next.o.wake = 1'b1;
                end
            end
        endcase
        st_next.o.sleep = st_next.lp_state != CSCR_LP_RUN && !st_next.deep_sel;
        st_next.o.deep_sleep = st_next.lp_state != CSCR_LP_RUN && st_next.deep_sel;

        // frame alignment on entry; stacked bit 9 undoes the pad on return
        if (core_in.exc_entry) begin
            st_next.o.frame_padded = st_reg.align8 && core_in.sp[2];
            st_next.o.frame_sp = st_reg.align8 ? {core_in.sp[31:3], 3'h0} :
                {core_in.sp[31:2], 2'h0};
        end
        if (core_in.exception_exit) begin
            st_next.o.restored_sp = core_in.stacked_status[CSCR_STACKED_ALIGN_BIT] ?
                core_in.sp + CSCR_PAD_BYTES : core_in.sp;
        end

        // bus faults at priority -1/-2; lockup holds until reset
        st_next.o.bus_fault_ignored = core_in.data_bus_fault && core_in.neg_priority && st_reg.bf_ignore;
        if (core_in.data_bus_fault && core_in.neg_priority && !st_reg.bf_ignore) begin
            st_next.o.lockup = 1'b1;
        end

        st_next.o.div_trap = core_in.div_exec && core_in.divisor_zero && st_reg.div_trap;
        st_next.o.div_zero_quotient = core_in.div_exec && core_in.divisor_zero && !st_reg.div_trap;
        st_next.o.usage_fault = core_in.access_valid && core_in.access_unaligned &&
            (core_in.access_multi_double || st_reg.misalign_trap);

        st_next.o.sw_trigger_allow = core_in.sw_trigger_write &&
            (core_in.sw_trigger_privileged || st_reg.unpriv_trig);
        st_next.o.sw_trigger_deny = core_in.sw_trigger_write && !core_in.sw_trigger_privileged &&
            !st_reg.unpriv_trig;

        st_next.o.thread_entry_ok = core_in.thread_return && (!core_in.others_active || st_reg.thread_any);
        st_next.o.thread_entry_fault = core_in.thread_return && core_in.others_active && !st_reg.thread_any;

        for (int i = 0; i < CSCR_PRI_COUNT; i++) begin
            st_next.o.group_pri[i] = group_part(st_next.pri[i], core_in.prigroup);
        end

        // synchronous reset: outputs clear and state takes its reset values on the edge that sees it low
        if (!reset_n_in) begin
            st_next = '0;
            st_next.wake_any = CSCR_LP_RESET[CSCR_LP_WAKE_ANY_BIT];
            st_next.deep_sel = CSCR_LP_RESET[CSCR_LP_DEEP_BIT];
            st_next.after_handler = CSCR_LP_RESET[CSCR_LP_AFTER_HANDLER_BIT];
            st_next.align8 = CSCR_CC_RESET[CSCR_CC_ALIGN8_BIT];
            st_next.bf_ignore = CSCR_CC_RESET[CSCR_CC_BF_IGNORE_BIT];
            st_next.div_trap = CSCR_CC_RESET[CSCR_CC_DIV_TRAP_BIT];
            st_next.misalign_trap = CSCR_CC_RESET[CSCR_CC_MISALIGN_BIT];
            st_next.unpriv_trig = CSCR_CC_RESET[CSCR_CC_UNPRIV_TRIG_BIT];
            st_next.thread_any = CSCR_CC_RESET[CSCR_CC_THREAD_ANY_BIT];
            st_next.pri = {CSCR_PRI_COUNT{CSCR_PRI_RESET}};
            st_next.lp_state = CSCR_LP_RUN;
        end
    end

    always_ff @(posedge clk_in) begin
        st_reg <= st_next;
    end

    // zero wait states; every answer is OKAY
    assign ahb_out.hreadyout = 1'b1;
    assign ahb_out.hresp = 1'b0;
    assign ahb_out.hrdata = st_reg.rdata;
    assign core_out = st_reg.o;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    AST_WAKE_DISABLED: assert property (
        st_reg.lp_state == CSCR_LP_EVENT_WAIT && core_in.disabled_irq_pending && st_reg.wake_any
        |=> st_reg.lp_state == CSCR_LP_RUN && core_out.wake)
        else $error("disabled interrupt did not wake with wake-on-pending set");
    AST_STAY_ASLEEP: assert property (
        st_reg.lp_state == CSCR_LP_EVENT_WAIT && !st_reg.wake_any && !core_in.send_event_instr &&
        !core_in.ext_event && !core_in.enabled_event && !core_in.enabled_irq_pending
        |=> st_reg.lp_state == CSCR_LP_EVENT_WAIT)
        else $error("woke from wait without an allowed source");
    AST_EVENT_LATCHED: assert property (
        st_reg.lp_state == CSCR_LP_RUN && st_reg.event_latch && core_in.wait_for_event_instr
        |=> st_reg.lp_state == CSCR_LP_RUN && !st_reg.event_latch)
        else $error("latched event not consumed by the next wait");
    AST_EVENT_SET: assert property (
        st_reg.lp_state == CSCR_LP_RUN && core_in.send_event_instr && !core_in.wait_for_event_instr
        |=> st_reg.event_latch)
        else $error("send-event while running was not latched");
    AST_SEND_EVENT_WAKE: assert property (
        st_reg.lp_state == CSCR_LP_EVENT_WAIT && (core_in.send_event_instr || core_in.ext_event)
        |=> !core_out.sleep && !core_out.deep_sleep)
        else $error("send or external event did not wake");
    AST_SLEEP_ON_EXIT: assert property (
        st_reg.lp_state == CSCR_LP_RUN && core_in.handler_exit && !core_in.wait_for_event_instr &&
        st_reg.after_handler && !(st_reg.ph_valid && st_reg.ph_write)
        |=> core_out.deep_sleep == $past(st_reg.deep_sel) && core_out.sleep != $past(st_reg.deep_sel))
        else $error("handler return did not enter the selected sleep");
    AST_FRAME_ALIGN: assert property (
        core_in.exc_entry && st_reg.align8
        |=> core_out.frame_sp[2:0] == 3'h0 && core_out.frame_padded == $past(core_in.sp[2]))
        else $error("exception frame not aligned to eight bytes");
    AST_RESTORE: assert property (
        core_in.exception_exit && core_in.stacked_status[CSCR_STACKED_ALIGN_BIT]
        |=> core_out.restored_sp == $past(core_in.sp) + CSCR_PAD_BYTES)
        else $error("stacked alignment bit not honoured on return");
    AST_LOCKUP: assert property (
        core_in.data_bus_fault && core_in.neg_priority && !st_reg.bf_ignore
        |=> core_out.lockup [*2])
        else $error("bus fault at top priority did not lock up");
    AST_DIVIDE: assert property (
        core_in.div_exec && core_in.divisor_zero
        |=> core_out.div_trap != core_out.div_zero_quotient && core_out.div_trap == $past(st_reg.div_trap))
        else $error("zero divisor handling does not follow the trap bit");
    AST_MULTI_FAULT: assert property (
        core_in.access_valid && core_in.access_unaligned && core_in.access_multi_double |=> core_out.usage_fault)
        else $error("unaligned multiple or doubleword access did not fault");
    AST_TRIGGER_GATE: assert property (
        core_in.sw_trigger_write && !core_in.sw_trigger_privileged
        |=> core_out.sw_trigger_allow == $past(st_reg.unpriv_trig))
        else $error("unprivileged trigger access not gated");
    AST_THREAD_ENTRY: assert property (
        core_in.thread_return && core_in.others_active && !st_reg.thread_any
        |=> core_out.thread_entry_fault && !core_out.thread_entry_ok)
        else $error("thread entry allowed with active exceptions");
    AST_PRI_LOW_ZERO: assert property (
        st_reg.ph_valid && !st_reg.ph_write &&
        (waddr == CSCR_OFS_PRI1 || waddr == CSCR_OFS_PRI2 || waddr == CSCR_OFS_PRI3)
        |-> ahb_out.hrdata[3:0] == 4'h0 && ahb_out.hrdata[11:8] == 4'h0 &&
        ahb_out.hrdata[19:16] == 4'h0 && ahb_out.hrdata[27:24] == 4'h0)
        else $error("unimplemented priority bits read non-zero");
    AST_LP_RESERVED: assert property (
        st_reg.ph_valid && !st_reg.ph_write && waddr == CSCR_OFS_LOW_POWER
        |-> ahb_out.hrdata[31:5] == 27'h000_0000 && ahb_out.hrdata[3] == 1'b0 && ahb_out.hrdata[0] == 1'b0)
        else $error("reserved low-power bits read non-zero");
    AST_SLEEP_HOLD: assert property (
        st_reg.lp_state == CSCR_LP_SLEEP && !core_in.enabled_irq_pending && !core_in.disabled_irq_pending
        |=> st_reg.lp_state == CSCR_LP_SLEEP)
        else $error("sleep after handler left without a pending interrupt");
    AST_UNPRIV_READ: assert property (
        addr_phase && !ahb_in.hprot[1] |=> ahb_out.hrdata == 32'h0000_0000)
        else $error("unprivileged read returned data");

    COV_WAIT_WAKE: cover property (
        st_reg.lp_state == CSCR_LP_EVENT_WAIT ##1 st_reg.lp_state == CSCR_LP_RUN);
    COV_SLEEP_EXIT: cover property (st_reg.lp_state == CSCR_LP_SLEEP ##1 core_out.wake);
    COV_BYTE_WRITE: cover property (st_reg.ph_valid && st_reg.ph_write && st_reg.ph_size == 3'h0);
    COV_LOCKUP: cover property (!core_out.lockup ##1 core_out.lockup);
    COV_EVENT_CONSUMED: cover property (st_reg.event_latch && core_in.wait_for_event_instr);
endmodule
`default_nettype wire

// ### design/cscr_pkg.sv
// shared constants and carriers for the core system control register bank
package cscr_pkg;
    localparam logic [7:0] CSCR_OFS_LOW_POWER = 8'h10;
    localparam logic [7:0] CSCR_OFS_CORE_CFG = 8'h14;
    localparam logic [7:0] CSCR_OFS_PRI1 = 8'h18;
    localparam logic [7:0] CSCR_OFS_PRI2 = 8'h1C;
    localparam logic [7:0] CSCR_OFS_PRI3 = 8'h20;
    // low_power_control fields
    localparam int CSCR_LP_AFTER_HANDLER_BIT = 1;
    localparam int CSCR_LP_DEEP_BIT = 2;
    localparam int CSCR_LP_WAKE_ANY_BIT = 4;
    localparam logic [31:0] CSCR_LP_RESET = 32'h0000_0000;
    // core_config_control fields
    localparam int CSCR_CC_THREAD_ANY_BIT = 0;
    localparam int CSCR_CC_UNPRIV_TRIG_BIT = 1;
    localparam int CSCR_CC_MISALIGN_BIT = 3;
    localparam int CSCR_CC_DIV_TRAP_BIT = 4;
    localparam int CSCR_CC_BF_IGNORE_BIT = 8;
    localparam int CSCR_CC_ALIGN8_BIT = 9;
    localparam logic [31:0] CSCR_CC_RESET = 32'h0000_0200;
    // priority fields: only the upper nibble is kept
    localparam int CSCR_PRI_COUNT = 6;
    localparam logic [3:0] CSCR_PRI_RESET = 4'h0;
    localparam int CSCR_STACKED_ALIGN_BIT = 9;
    localparam logic [31:0] CSCR_PAD_BYTES = 32'h0000_0004;
    localparam logic [1:0] CSCR_HTRANS_NONSEQ = 2'h2;

    typedef enum logic [1:0] {
        CSCR_LP_RUN,
        CSCR_LP_EVENT_WAIT,
        CSCR_LP_SLEEP
    } cscr_lp_state_t;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [3:0] hprot;
        logic [31:0] hwdata;
        logic hready;
    } cscr_ahb_req_t;

    typedef struct packed {
        logic hreadyout;
        logic hresp;
        logic [31:0] hrdata;
    } cscr_ahb_rsp_t;

    typedef struct packed {
        logic wait_for_event_instr;
        logic send_event_instr;
        logic ext_event;
        logic enabled_event;
        logic enabled_irq_pending;
        logic disabled_irq_pending;
        logic handler_exit;
        logic exc_entry;
        logic exception_exit;
        logic [31:0] sp;
        logic [31:0] stacked_status;
        logic data_bus_fault;
        logic neg_priority;
        logic div_exec;
        logic divisor_zero;
        logic access_valid;
        logic access_unaligned;
        logic access_multi_double;
        logic sw_trigger_write;
        logic sw_trigger_privileged;
        logic thread_return;
        logic others_active;
        logic [2:0] prigroup;
    } cscr_core_in_t;

    typedef struct packed {
        logic sleep;
        logic deep_sleep;
        logic wake;
        logic [31:0] frame_sp;
        logic frame_padded;
        logic [31:0] restored_sp;
        logic bus_fault_ignored;
        logic lockup;
        logic div_trap;
        logic div_zero_quotient;
        logic usage_fault;
        logic sw_trigger_allow;
        logic sw_trigger_deny;
        logic thread_entry_ok;
        logic thread_entry_fault;
        logic [CSCR_PRI_COUNT-1:0][7:0] group_pri;
    } cscr_core_out_t;
endpackage

// ### bench/test_core_system_control_regs.sv
// self-checking bench for the core system control register bank
`timescale 1ns/1ps
`default_nettype none
module test_core_system_control_regs;
    import cscr_pkg::*;
    typedef struct packed {
        logic [7:0] ofs;
        logic [31:0] wdata;
        logic [31:0] exp;
    } cscr_row_t;
    logic clk_in;
    logic reset_n_in;
    cscr_ahb_req_t req;
    cscr_ahb_req_t ahb_s;
    cscr_ahb_rsp_t ahb_out;
    cscr_core_in_t core;
    cscr_core_out_t core_out;
    cscr_core_in_t v;
    cscr_row_t rows [6];
    logic [31:0] rd;
    int error_cnt;
    int checks_done;

    // the lone slave's ready is the bus ready
    always_comb begin
        ahb_s = req;
        ahb_s.hready = ahb_out.hreadyout;
    end

    cscr_regs uut (.clk_in(clk_in), .reset_n_in(reset_n_in), .ahb_in(ahb_s), .ahb_out(ahb_out),
        .core_in(core), .core_out(core_out));

    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    task automatic tally_and_finish();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    // bounded wait; a stuck ready ends the run
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge clk_in);
        while (ahb_out.hreadyout !== 1'b1) begin
            n++;
            if (n > 16) begin
                error_cnt++;
                $display("[FAIL] %0t bus wait timed out", $time);
                tally_and_finish();
            end
            @(posedge clk_in);
        end
    endtask

    task automatic bus(input logic [7:0] ofs, input logic wr, input logic [31:0] wd, input logic priv,
        output logic [31:0] rdata);
        @(posedge clk_in);
        req.hsel <= 1'b1;
        req.haddr <= {24'h00_0000, ofs};
        req.htrans <= CSCR_HTRANS_NONSEQ;
        req.hwrite <= wr;
        req.hsize <= 3'h2;
        req.hprot <= {2'b00, priv, 1'b1};
        wait_ready();
        req.htrans <= 2'h0;
        req.hwdata <= wd;
        wait_ready();
        rdata = ahb_out.hrdata;
    endtask

    // one cycle of core-side stimulus, outputs looked at one edge later
    task automatic apply(input cscr_core_in_t c);
        @(posedge clk_in);
        core <= c;
        @(posedge clk_in);
        core <= '0;
        #1;
    endtask

    initial begin
        req = '0;
        core = '0;
        reset_n_in = 1'b0;
        error_cnt = 0;
        checks_done = 0;
        rows[0] = '{CSCR_OFS_LOW_POWER, 32'hFFFF_FFFF, 32'h0000_0016};
        rows[1] = '{CSCR_OFS_CORE_CFG, 32'hFFFF_FFFF, 32'h0000_031B};
        rows[2] = '{CSCR_OFS_PRI1, 32'hFFFF_FFFF, 32'h00F0_F0F0};
        rows[3] = '{CSCR_OFS_PRI2, 32'hFFFF_FFFF, 32'hF000_0000};
        rows[4] = '{CSCR_OFS_PRI3, 32'hFFFF_FFFF, 32'hF0F0_0000};
        rows[5] = '{8'h30, 32'hFFFF_FFFF, 32'h0000_0000};
        repeat (20) @(posedge clk_in);
        reset_n_in <= 1'b1;
        bus(CSCR_OFS_LOW_POWER, 1'b0, 32'h0, 1'b1, rd);
        chk_word(rd, CSCR_LP_RESET, "lp reset");
        bus(CSCR_OFS_CORE_CFG, 1'b0, 32'h0, 1'b1, rd);
        chk_word(rd, CSCR_CC_RESET, "cc reset");
        foreach (rows[i]) begin
            bus(rows[i].ofs, 1'b1, rows[i].wdata, 1'b1, rd);
            bus(rows[i].ofs, 1'b0, 32'h0, 1'b1, rd);
            chk_word(rd, rows[i].exp, "reg row");
        end
        // unprivileged access is silently dropped
        bus(CSCR_OFS_LOW_POWER, 1'b1, 32'h0, 1'b0, rd);
        bus(CSCR_OFS_LOW_POWER, 1'b0, 32'h0, 1'b0, rd);
        chk_word(rd, 32'h0, "unpriv read");
        chk_bit(ahb_out.hresp, 1'b0, "unpriv okay");
        bus(CSCR_OFS_LOW_POWER, 1'b0, 32'h0, 1'b1, rd);
        chk_word(rd, 32'h0000_0016, "unpriv write");
        bus(CSCR_OFS_LOW_POWER, 1'b1, 32'h0, 1'b1, rd);
        // traps on
        bus(CSCR_OFS_CORE_CFG, 1'b1, 32'h0000_0018, 1'b1, rd);
        v = '0;
        v.div_exec = 1'b1;
        v.divisor_zero = 1'b1;
        apply(v);
        chk_bit(core_out.div_trap, 1'b1, "div trap");
        v = '0;
        v.access_valid = 1'b1;
        v.access_unaligned = 1'b1;
        apply(v);
        chk_bit(core_out.usage_fault, 1'b1, "unaligned trap");
        // traps off, privilege gates closed
        bus(CSCR_OFS_CORE_CFG, 1'b1, 32'h0, 1'b1, rd);
        apply(v);
        chk_bit(core_out.usage_fault, 1'b0, "unaligned no trap");
        v.access_multi_double = 1'b1;
        apply(v);
        chk_bit(core_out.usage_fault, 1'b1, "multi always");
        v = '0;
        v.div_exec = 1'b1;
        v.divisor_zero = 1'b1;
        apply(v);
        chk_bit(core_out.div_trap, 1'b0, "div no trap");
        chk_bit(core_out.div_zero_quotient, 1'b1, "div quotient");
        v = '0;
        v.sw_trigger_write = 1'b1;
        v.thread_return = 1'b1;
        v.others_active = 1'b1;
        v.exc_entry = 1'b1;
        v.sp = 32'h0000_0104;
        apply(v);
        chk_bit(core_out.sw_trigger_deny, 1'b1, "trigger deny");
        chk_bit(core_out.thread_entry_fault, 1'b1, "thread fault");
        chk_bit(core_out.frame_padded, 1'b0, "align4");
        chk_word(core_out.frame_sp, 32'h0000_0104, "frame sp4");
        bus(CSCR_OFS_CORE_CFG, 1'b1, 32'h0000_0303, 1'b1, rd);
        apply(v);
        chk_bit(core_out.sw_trigger_allow, 1'b1, "trigger allow");
        chk_bit(core_out.thread_entry_ok, 1'b1, "thread ok");
        chk_bit(core_out.frame_padded, 1'b1, "align8");
        chk_word(core_out.frame_sp, 32'h0000_0100, "frame sp8");
        v = '0;
        v.exception_exit = 1'b1;
        v.sp = 32'h0000_0200;
        v.stacked_status = 32'h0000_0200;
        apply(v);
        chk_word(core_out.restored_sp, 32'h0000_0204, "restore sp");
        v.stacked_status = 32'h0000_0000;
        apply(v);
        chk_word(core_out.restored_sp, 32'h0000_0200, "restore no pad");
        v = '0;
        v.data_bus_fault = 1'b1;
        v.neg_priority = 1'b1;
        apply(v);
        chk_bit(core_out.bus_fault_ignored, 1'b1, "bf ignore");
        chk_bit(core_out.lockup, 1'b0, "no lockup");
        // low-power entry and the wake sources
        v = '0;
        v.wait_for_event_instr = 1'b1;
        apply(v);
        chk_bit(core_out.sleep, 1'b1, "wait sleep");
        chk_bit(core_out.deep_sleep, 1'b0, "not deep");
        v = '0;
        v.disabled_irq_pending = 1'b1;
        apply(v);
        chk_bit(core_out.wake, 1'b0, "disabled no wake");
        bus(CSCR_OFS_LOW_POWER, 1'b1, 32'h0000_0010, 1'b1, rd);
        apply(v);
        chk_bit(core_out.wake, 1'b1, "disabled wakes");
        v = '0;
        v.send_event_instr = 1'b1;
        apply(v);
        v = '0;
        v.wait_for_event_instr = 1'b1;
        apply(v);
        chk_bit(core_out.sleep, 1'b0, "latched event");
        bus(CSCR_OFS_LOW_POWER, 1'b1, 32'h0000_0004, 1'b1, rd);
        apply(v);
        chk_bit(core_out.deep_sleep, 1'b1, "deep sleep");
        v = '0;
        v.ext_event = 1'b1;
        apply(v);
        chk_bit(core_out.wake, 1'b1, "ext wake");
        bus(CSCR_OFS_LOW_POWER, 1'b1, 32'h0000_0002, 1'b1, rd);
        v = '0;
        v.handler_exit = 1'b1;
        apply(v);
        chk_bit(core_out.sleep, 1'b1, "sleep on exit");
        v = '0;
        v.enabled_irq_pending = 1'b1;
        apply(v);
        chk_bit(core_out.wake, 1'b1, "irq wake");
        // group part only at binary point 5
        bus(CSCR_OFS_PRI1, 1'b1, 32'h0000_A050, 1'b1, rd);
        v = '0;
        v.prigroup = 3'h5;
        apply(v);
        chk_word({24'h0, core_out.group_pri[0]}, 32'h0000_0040, "group pri4");
        chk_word({24'h0, core_out.group_pri[1]}, 32'h0000_0080, "group pri5");
        bus(CSCR_OFS_CORE_CFG, 1'b1, 32'h0, 1'b1, rd);
        v = '0;
        v.data_bus_fault = 1'b1;
        v.neg_priority = 1'b1;
        apply(v);
        apply('0);
        chk_bit(core_out.lockup, 1'b1, "lockup sticky");
        // second reset in mid-run clears the sticky state
        @(posedge clk_in);
        reset_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        reset_n_in <= 1'b1;
        #1;
        chk_bit(core_out.lockup, 1'b0, "lockup reset");
        bus(CSCR_OFS_CORE_CFG, 1'b0, 32'h0, 1'b1, rd);
        chk_word(rd, CSCR_CC_RESET, "cc re-reset");
        tally_and_finish();
    end
endmodule
`default_nettype wire
